// ### rtl/ssp_cfg.svh
// Register map, field positions and timing counts of the serial port
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH

// Register indices; the APB byte address is four times the index
`define SSP_IDX_CONTROL 6'h0a
`define SSP_IDX_STATUS  6'h0b
`define SSP_IDX_DATA    6'h0c

// Control register fields
`define SSP_CTL_IRQ_EN  7
`define SSP_CTL_PORT_EN 6
`define SSP_CTL_LSB_1ST 5
`define SSP_CTL_MASTER  4
`define SSP_CTL_CLR     3
`define SSP_CTL_IDLE_LO 2
`define SSP_CTL_RATE_HI 1
`define SSP_CTL_RATE_LO 0

// Status register fields
`define SSP_STS_DONE    7
`define SSP_STS_COL     6

`define SSP_CTL_RESET   8'h00

// Half periods of the master clock in system clocks (divide 64/32/16/8)
`define SSP_HALF_DIV64  6'h20
`define SSP_HALF_DIV32  6'h10
`define SSP_HALF_DIV16  6'h08
`define SSP_HALF_DIV8   6'h04

// Clock transitions per byte: idle high, and idle low with lead and tail
`define SSP_TOGGLES_IDLE_HI 5'h10
`define SSP_TOGGLES_IDLE_LO 5'h12

`define SSP_LAST_BIT    4'h7

`endif

// ### rtl/ssp_pkg.sv
// Types shared by the serial port design
package ssp_pkg;
  typedef enum logic {
    SSP_M_IDLE,
    SSP_M_RUN
  } ssp_mgen_t;
endpackage

// ### rtl/ssp_shifter.sv
// Single data register that doubles as the serial shift register
`timescale 1ns/1ps
module ssp_shifter #(
  parameter int DATA_W = 8
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              load,
  input  wire logic [DATA_W-1:0] load_data,
  input  wire logic              shift_out,
  input  wire logic              shift_in,
  input  wire logic              low_bit_first,
  input  wire logic              serial_in,
  output logic      [DATA_W-1:0] data,
  output logic                   serial_out
);
  wire [DATA_W-1:0] next_data = low_bit_first ?
                                {serial_in, data[DATA_W-1:1]} :
                                {data[DATA_W-2:0], serial_in};

  // Not reset; a write mid-transfer wins over the shift and corrupts it
  always_ff @(posedge clock) begin
    if (load) begin
      data <= load_data;
    end else if (shift_in) begin
      data <= next_data;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      serial_out <= 1'b0;
    end else if (shift_out) begin
      serial_out <= low_bit_first ? data[0] : data[DATA_W-1];
    end
  end
endmodule

// ### rtl/ssp_simple_serial_port.sv
// Three-wire synchronous serial port with APB registers
//
// Contract
// - Enabled interrupt follows the done flag
// - Disabling interrupt keeps the done flag
// - Late disable drops request; processor takes reset
// - Enable hands three pins to the port
// - Disable aborts transfer, clears bit counter
// - Bit order: one is low bit first
// - Master data write starts divided clock
// - Master bit always writable; clearing aborts
// - Data pins same in master and slave
// - Flag clear bit clears done, reads zero
// - Change on fall, capture on rise; idle
// - Rate bits divide by 64/32/16/8
// - Done set on last rising edge
// - Done cleared by status-data or clear bit
// - Early clear is overridden at last edge
// - Data access mid-transfer sets collision
// - Collision cleared by status-data, may reset
// - One unbuffered data register, not reset
// - Eight bits per transfer, end eighth rise
// - Control register at index 0x0a
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_simple_serial_port
  import ssp_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic                   xfer_irq,
  input  wire logic [2:0]        gpio_out,
  input  wire logic [2:0]        gpio_oe,
  output logic      [2:0]        gpio_in,
  input  wire logic              port_pin_five_in,
  output logic                   port_pin_five_out,
  output logic                   port_pin_five_oe,
  input  wire logic              port_pin_six_in,
  output logic                   port_pin_six_out,
  output logic                   port_pin_six_oe,
  input  wire logic              port_pin_seven_in,
  output logic                   port_pin_seven_out,
  output logic                   port_pin_seven_oe
);
  // Control state
  logic              xfer_irq_enable;
  logic              port_enable;
  logic              low_bit_first;
  logic              master_select;
  logic              clock_idle_level;
  logic [1:0]        rate_select;
  logic              master_prev;
  // Status state
  logic              xfer_done_flag;
  logic              access_collision_flag;
  logic              clear_armed;
  // Transfer state
  logic [3:0]        bit_cnt;
  logic              half_bit;
  logic              in_xfer;
  logic              tail_pending;
  logic              sck_prev;
  logic              mclk;
  logic [5:0]        half_cnt;
  logic [4:0]        toggle_cnt;
  ssp_mgen_t         m_state;
  logic [2:0]        pin_sync;
  logic [DATA_W-1:0] shift_data;
  logic              serial_out_bit;

  // APB decode; zero wait states, read data captured in the setup cycle
  wire [ADDR_W-1:0] ctl_addr = ADDR_W'({`SSP_IDX_CONTROL, 2'b00});
  wire [ADDR_W-1:0] sts_addr = ADDR_W'({`SSP_IDX_STATUS, 2'b00});
  wire [ADDR_W-1:0] dat_addr = ADDR_W'({`SSP_IDX_DATA, 2'b00});
  wire              hit_ctl  = paddr == ctl_addr;
  wire              hit_sts  = paddr == sts_addr;
  wire              hit_dat  = paddr == dat_addr;
  wire              hit_any  = hit_ctl | hit_sts | hit_dat;
  wire              setup    = psel & ~penable;
  wire              fire     = psel & penable;
  wire              wr_ctl   = fire & pwrite & hit_ctl;
  wire              rd_sts   = fire & ~pwrite & hit_sts;
  wire              acc_dat  = fire & hit_dat;
  wire              wr_dat   = acc_dat & pwrite;

  assign pready = 1'b1;

  // Flag clear bit is write-only and always reads zero
  wire [7:0] ctl_rd;
  assign ctl_rd[`SSP_CTL_IRQ_EN]  = xfer_irq_enable;
  assign ctl_rd[`SSP_CTL_PORT_EN] = port_enable;
  assign ctl_rd[`SSP_CTL_LSB_1ST] = low_bit_first;
  assign ctl_rd[`SSP_CTL_MASTER]  = master_select;
  assign ctl_rd[`SSP_CTL_CLR]     = 1'b0;
  assign ctl_rd[`SSP_CTL_IDLE_LO] = clock_idle_level;
  assign ctl_rd[`SSP_CTL_RATE_HI] = rate_select[1];
  assign ctl_rd[`SSP_CTL_RATE_LO] = rate_select[0];

  wire [7:0] sts_rd;
  assign sts_rd[`SSP_STS_DONE] = xfer_done_flag;
  assign sts_rd[`SSP_STS_COL]  = access_collision_flag;
  assign sts_rd[5:0]           = 6'h00;

  wire [7:0] rd_byte = hit_ctl ? ctl_rd :
                       hit_sts ? sts_rd :
                       hit_dat ? shift_data : 8'h00;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= {24'h00_0000, rd_byte};
      pslverr <= ~hit_any;
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

  // Control register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      xfer_irq_enable  <= 1'b0;
      port_enable      <= 1'b0;
      low_bit_first    <= 1'b0;
      master_select    <= 1'b0;
      clock_idle_level <= 1'b0;
      rate_select      <= 2'h0;
    end else if (wr_ctl) begin
      xfer_irq_enable  <= pwdata[`SSP_CTL_IRQ_EN];
      port_enable      <= pwdata[`SSP_CTL_PORT_EN];
      low_bit_first    <= pwdata[`SSP_CTL_LSB_1ST];
      master_select    <= pwdata[`SSP_CTL_MASTER];
      clock_idle_level <= pwdata[`SSP_CTL_IDLE_LO];
      rate_select      <= {pwdata[`SSP_CTL_RATE_HI],
                           pwdata[`SSP_CTL_RATE_LO]};
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      master_prev <= 1'b0;
    end else begin
      master_prev <= master_select;
    end
  end

  // Request drops as soon as the enable falls; a vector fetch already
  // under way finds no source and the core falls back to reset
  assign xfer_irq = xfer_irq_enable & xfer_done_flag;

  // Pins are synchronised once and shared by the port and the GPIO reader
  ssp_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .async_in ({port_pin_seven_in, port_pin_six_in, port_pin_five_in}),
    .sync_out (pin_sync)
  );
  assign gpio_in = pin_sync;

  // Abort on disable or on a falling master select
  wire master_fall = master_prev & ~master_select;
  wire abort_x     = ~port_enable | master_fall;

  // One edge detector serves both modes; the clock source differs, and master-mode edges are gated by sck_live
  wire idle_level = ~clock_idle_level;
  wire sck_level  = master_select ? mclk : pin_sync[2];
  // An idle master clock only moves when its idle level is rewritten;
  // that step is no bit edge and must not open a frame
  wire sck_live   = ~master_select | (m_state != SSP_M_IDLE) |
                    in_xfer | tail_pending;
  wire fall_ev    = port_enable & sck_live & sck_prev & ~sck_level;
  wire rise_ev    = port_enable & sck_live & ~sck_prev & sck_level;
  wire shift_out  = fall_ev & ~tail_pending & ~half_bit & ~abort_x;
  wire shift_in   = rise_ev & half_bit & ~abort_x;
  wire final_rise = shift_in & (bit_cnt == `SSP_LAST_BIT);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sck_prev <= 1'b1;
    end else begin
      sck_prev <= sck_level;
    end
  end

  // With idle low the return to idle is one extra fall; it must not
  // shift, so it is swallowed by the tail marker
  always_ff @(posedge clock) begin
    if (sys_rst || abort_x) begin
      bit_cnt      <= 4'h0;
      half_bit     <= 1'b0;
      in_xfer      <= 1'b0;
      tail_pending <= 1'b0;
    end else if (fall_ev) begin
      if (tail_pending) begin
        tail_pending <= 1'b0;
      end else begin
        half_bit <= 1'b1;
        in_xfer  <= 1'b1;
      end
    end else if (shift_in) begin
      half_bit <= 1'b0;
      if (final_rise) begin
        bit_cnt      <= 4'h0;
        in_xfer      <= 1'b0;
        tail_pending <= clock_idle_level;
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
      end
    end
  end

  ssp_shifter #(
    .DATA_W (DATA_W)
  ) u_shifter (
    .clock         (clock),
    .sys_rst       (sys_rst),
    .load          (wr_dat),
    .load_data     (pwdata[DATA_W-1:0]),
    .shift_out     (shift_out),
    .shift_in      (shift_in),
    .low_bit_first (low_bit_first),
    .serial_in     (pin_sync[1]),
    .data          (shift_data),
    .serial_out    (serial_out_bit)
  );

  // Master clock generator
  wire [5:0] half_target = (rate_select == 2'h0) ? `SSP_HALF_DIV64 :
                           (rate_select == 2'h1) ? `SSP_HALF_DIV32 :
                           (rate_select == 2'h2) ? `SSP_HALF_DIV16 :
                                                   `SSP_HALF_DIV8;
  wire [4:0] toggle_total = clock_idle_level ? `SSP_TOGGLES_IDLE_LO :
                                               `SSP_TOGGLES_IDLE_HI;
  wire       m_idle       = m_state == SSP_M_IDLE;
  wire       m_start      = wr_dat & port_enable & master_select &
                            m_idle & ~in_xfer;
  wire       half_done    = half_cnt == half_target - 6'h01;

  always_ff @(posedge clock) begin
    if (sys_rst || abort_x || !master_select) begin
      m_state    <= SSP_M_IDLE;
      mclk       <= idle_level;
      half_cnt   <= 6'h00;
      toggle_cnt <= 5'h00;
    end else begin
      case (m_state)
        SSP_M_IDLE: begin
          mclk       <= idle_level;
          half_cnt   <= 6'h00;
          toggle_cnt <= 5'h00;
          if (m_start) begin
            m_state <= SSP_M_RUN;
          end
        end
        SSP_M_RUN: begin
          if (half_done) begin
            half_cnt   <= 6'h00;
            mclk       <= ~mclk;
            toggle_cnt <= toggle_cnt + 5'h01;
            if (toggle_cnt + 5'h01 == toggle_total) begin
              m_state <= SSP_M_IDLE;
            end
          end else begin
            half_cnt <= half_cnt + 6'h01;
          end
        end
        default: m_state <= SSP_M_IDLE;
      endcase
    end
  end

  // Status flags; a set in the same cycle as a clear wins
  wire clr_done = (wr_ctl & pwdata[`SSP_CTL_CLR]) |
                  (acc_dat & clear_armed);
  wire set_col  = acc_dat & in_xfer;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      xfer_done_flag <= 1'b0;
    end else if (final_rise) begin
      xfer_done_flag <= 1'b1;
    end else if (clr_done) begin
      xfer_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      access_collision_flag <= 1'b0;
    end else if (set_col) begin
      access_collision_flag <= 1'b1;
    end else if (acc_dat && clear_armed) begin
      access_collision_flag <= 1'b0;
    end
  end

  // Status read arms the clear only if done was seen set
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      clear_armed <= 1'b0;
    end else if (rd_sts) begin
      clear_armed <= xfer_done_flag;
    end else if (acc_dat) begin
      clear_armed <= 1'b0;
    end
  end

  // Pin takeover; GPIO writes no longer reach pins five to seven
  assign port_pin_five_out  = port_enable ? serial_out_bit : gpio_out[0];
  assign port_pin_five_oe   = port_enable | gpio_oe[0];
  assign port_pin_six_out   = gpio_out[1];
  assign port_pin_six_oe    = ~port_enable & gpio_oe[1];
  assign port_pin_seven_out = port_enable ? mclk : gpio_out[2];
  assign port_pin_seven_oe  = port_enable ? master_select :
                                            gpio_oe[2];

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_irq_follows_flag;
    xfer_irq_enable && xfer_done_flag |-> xfer_irq;
  endproperty
  a_irq_follows_flag: assert property (p_irq_follows_flag)
    else $error("interrupt not raised with flag and enable");

  property p_disable_keeps_flag;
    $fell(xfer_irq_enable) && $past(xfer_done_flag) |-> xfer_done_flag;
  endproperty
  a_disable_keeps_flag: assert property (p_disable_keeps_flag)
    else $error("clearing interrupt enable changed done flag");

  property p_pins_taken;
    port_enable |-> port_pin_five_oe && !port_pin_six_oe &&
                    port_pin_seven_oe == master_select;
  endproperty
  a_pins_taken: assert property (p_pins_taken)
    else $error("pin directions wrong while port enabled");

  property p_disable_aborts;
    $fell(port_enable) |=> bit_cnt == 4'h0 && !in_xfer && m_idle;
  endproperty
  a_disable_aborts: assert property (p_disable_aborts)
    else $error("disable did not abort the transfer");

  property p_fast_rate;
    !m_idle && rate_select == 2'h3 && $changed(mclk) && !abort_x
      |=> $stable(mclk)[*3];
  endproperty
  a_fast_rate: assert property (p_fast_rate)
    else $error("divide by eight half period too short");

  property p_idle_level;
    m_idle && master_select && port_enable |=>
      mclk == $past(idle_level);
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("master clock not at idle level");

  property p_clear_bit;
    wr_ctl && pwdata[`SSP_CTL_CLR] && !final_rise |=> !xfer_done_flag;
  endproperty
  a_clear_bit: assert property (p_clear_bit)
    else $error("flag clear bit did not clear done");

  property p_done_on_last;
    final_rise |=> xfer_done_flag && !in_xfer;
  endproperty
  a_done_on_last: assert property (p_done_on_last)
    else $error("done not set on last rising edge");

  property p_collision;
    set_col && !abort_x |=> access_collision_flag;
  endproperty
  a_collision: assert property (p_collision)
    else $error("mid-transfer data access missed collision");

  sequence s_status_seen;
    rd_sts && xfer_done_flag;
  endsequence
  sequence s_data_access;
    (!acc_dat && !rd_sts) [*2] ##1 (acc_dat && !in_xfer && !final_rise);
  endsequence
  property p_status_data_clears;
    s_status_seen ##1 s_data_access |=> !xfer_done_flag &&
                                        !access_collision_flag;
  endproperty
  a_status_data_clears: assert property (p_status_data_clears)
    else $error("status then data access did not clear flags");
endmodule

// ### rtl/ssp_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module ssp_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      meta     <= '0;
      sync_out <= '0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// ### verification/ssp_far_end.sv
// Far-side serial peripheral that can also clock one byte as master
`timescale 1ns/1ps
module ssp_far_end #(
  parameter int HALF = 20
) (
  input  wire logic       clock,
  input  wire logic       sck,
  input  wire logic       serial_out_pin,
  input  wire logic       drive_clk,
  input  wire logic       idle_low,
  input  wire logic [7:0] tx,
  input  wire logic       go,
  output logic            sck_out,
  output logic            serial_in_pin,
  output logic [7:0]      rx,
  output logic            busy
);
  logic       sck_q = 1'b1;
  logic       armed = 1'b0;
  logic [3:0] nb    = 4'h8;
  logic [4:0] tog   = 5'h00;
  logic [5:0] cnt   = 6'h00;
  logic [5:0] hold  = 6'h00;
  logic [7:0] sh    = 8'h00;

  initial sck_out = 1'b1;
  initial serial_in_pin = 1'b0;
  initial rx = 8'h00;
  assign busy = (tog != 5'h00);

  always @(posedge clock) begin
    sck_q <= sck;
    if (!drive_clk || tog == 5'h00) begin
      sck_out <= ~idle_low;
      cnt <= 6'h00;
    end else if (cnt == HALF - 1) begin
      cnt <= 6'h00;
      sck_out <= ~sck_out;
      tog <= tog - 5'h01;
    end else begin
      cnt <= cnt + 6'h01;
    end
    // Data changes on a fall, eight bits only
    if (sck_q && !sck && nb < 4'h8) begin
      serial_in_pin <= sh[7];
      sh <= {sh[6:0], 1'b0};
      nb <= nb + 4'h1;
      armed <= 1'b1;
    end
    // Only a rise after a fall captures, so an idle-low lead rise is ignored
    if (!sck_q && sck && armed) begin
      rx <= {rx[6:0], serial_out_pin};
      armed <= 1'b0;
      if (nb == 4'h8) begin
        hold <= 6'h1e;
      end
    end
    // Line inverted once the hold time has run out
    if (hold == 6'h01) begin
      serial_in_pin <= ~serial_in_pin;
    end
    if (hold != 6'h00) begin
      hold <= hold - 6'h01;
    end
    if (go) begin
      sh <= tx;
      nb <= 4'h0;
      // A frame clocked by the port leaves no pulses pending here
      tog <= !drive_clk ? 5'h00 : idle_low ? 5'h12 : 5'h10;
    end
  end
endmodule

// ### verification/ssp_simple_serial_port_tb.sv
// Self-checking bench for the serial port with a far-side model
`timescale 1ns/1ps
`include "ssp_cfg.svh"
module ssp_simple_serial_port_tb;
  localparam logic [7:0] A_CTL = {`SSP_IDX_CONTROL, 2'b00};
  localparam logic [7:0] A_STS = {`SSP_IDX_STATUS, 2'b00};
  localparam logic [7:0] A_DAT = {`SSP_IDX_DATA, 2'b00};
  logic        clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0, f_tx = 0, f_rx, v;
  logic [31:0] pwdata = 0, prdata, r;
  logic        pready, pslverr, xfer_irq, e, tgl = 0, sck_q = 1;
  logic [2:0]  gpio_out = 0, gpio_oe = 0, gpio_in;
  logic        o5, e5, o6, e6, o7, e7, fsck, fsdi, f_busy;
  logic        f_drv = 0, f_idle = 0, f_go = 0;
  int          failures = 0, total_checks = 0, cyc = 0, t_last = 0, hp = 0;
  // Undriven data-out pin toggles so a stale value never passes
  wire p5 = e5 ? o5 : tgl;
  wire p6 = e6 ? o6 : fsdi;
  wire p7 = e7 ? o7 : fsck;

  ssp_simple_serial_port u_ssp_simple_serial_port (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .xfer_irq(xfer_irq),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
    .port_pin_five_in(p5), .port_pin_five_out(o5), .port_pin_five_oe(e5),
    .port_pin_six_in(p6), .port_pin_six_out(o6), .port_pin_six_oe(e6),
    .port_pin_seven_in(p7), .port_pin_seven_out(o7), .port_pin_seven_oe(e7));
  ssp_far_end u_ssp_far_end (
    .clock(clock), .sck(p7), .serial_out_pin(p5), .drive_clk(f_drv),
    .idle_low(f_idle), .tx(f_tx), .go(f_go), .sck_out(fsck), .serial_in_pin(fsdi),
    .rx(f_rx), .busy(f_busy));

  always #2 clock = ~clock;
  always @(posedge clock) begin
    tgl <= ~tgl;
    cyc <= cyc + 1;
    sck_q <= p7;
    if (p7 !== sck_q) begin
      hp <= cyc - t_last;
      t_last <= cyc;
    end
  end

  task automatic chk(input string n, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, d,
                     output logic [31:0] rd_v, output logic err);
    @(posedge clock);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clock);
    penable <= 1;
    do @(posedge clock); while (pready !== 1'b1);
    rd_v = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [31:0] x;
    logic        y;
    apb(1'b1, a, d, x, y);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    logic y;
    apb(1'b0, a, 8'h00, x, y);
  endtask
  function automatic logic [7:0] rev(input logic [7:0] b, input logic f);
    rev = b;
    if (f) begin
      rev = {<<{b}};
    end
  endfunction
  task automatic wait_done(output logic [31:0] s);
    s = 0;
    for (int i = 0; i < 3000 && s[7] !== 1'b1; i++) rd(A_STS, s);
  endtask
  // Data write first, since it is what starts a master transfer
  task automatic start(input logic [7:0] d);
    wr(A_DAT, d);
    f_tx <= $urandom;
    f_go <= 1;
    @(posedge clock);
    f_go <= 0;
  endtask
  task automatic xfer(input logic [7:0] c, input logic w1);
    logic [7:0]  d;
    logic [31:0] s;
    d = $urandom;
    wr(A_CTL, 8'h00);
    f_idle <= c[2];
    f_drv <= ~c[4];
    // Far clock level must pass the pin synchroniser before enabling
    repeat (4) @(posedge clock);
    wr(A_CTL, c);
    start(d);
    wait_done(s);
    chk("irq", xfer_irq, c[7]);
    if (c[7]) begin
      wr(A_CTL, c & 8'h7f);
      rd(A_STS, s);
      chk("irq_off", {xfer_irq, s[7]}, 2'b01);
    end
    if (w1) begin
      wr(A_CTL, c | 8'h08);
      rd(A_STS, s);
      chk("w1_clear", s, 0);
    end
    rd(A_DAT, s);
    chk("rx", s, rev(f_tx, c[5]));
    chk("far_rx", f_rx, rev(d, c[5]));
    rd(A_STS, s);
    chk("sts_clear", s, 0);
    // Idle-low frames end with a return fall one half period later
    repeat (70) @(posedge clock);
    chk("half", hp, c[4] ? 32 >> c[1:0] : 20);
    chk("pins", {p7, e5, e6, e7}, {~c[2], 2'b10, c[4]});
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    failures++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h884e));
    repeat (4) @(posedge clock);
    sys_rst <= 0;
    rd(A_CTL, r);
    chk("ctl_reset", r, 0);
    rd(A_STS, r);
    chk("sts_reset", {r[31:1], xfer_irq}, 0);
    apb(1'b0, 8'h3c, 8'h00, r, e);
    chk("unmapped", {r[30:0], e}, 1);
    v = ($urandom & 8'hb7) | 8'h08;
    wr(A_CTL, v);
    rd(A_CTL, r);
    chk("ctl_rw", r, v & 8'hf7);
    wr(A_CTL, 8'h00);
    v = $urandom;
    wr(A_DAT, v);
    rd(A_DAT, r);
    chk("data_rw", r, v);
    gpio_out <= $urandom;
    gpio_oe <= 3'h7;
    repeat (4) @(posedge clock);
    chk("gpio", {p7, p6, p5, gpio_in}, {gpio_out, gpio_out});
    for (int k = 0; k < 2; k++) begin
      wr(A_CTL, 8'h50);
      start($urandom);
      repeat (100) @(posedge clock);
      wr(A_CTL, k ? 8'h40 : 8'h10);
      repeat (600) @(posedge clock);
      rd(A_STS, r);
      chk("abort", r, 0);
      if (k == 0) chk("abort_pins", {p7, p6, p5}, gpio_out);
    end
    // Early flag clear and a data access in mid-transfer
    wr(A_CTL, 8'h50);
    start(8'h3c);
    repeat (60) @(posedge clock);
    wr(A_CTL, 8'h58);
    wr(A_DAT, 8'h81);
    wait_done(r);
    chk("collision", r, 32'hc0);
    rd(A_DAT, r);
    rd(A_STS, r);
    chk("col_clear", r, 0);
    for (int i = 0; i < 8; i++) begin
      gpio_out <= $urandom;
      xfer({i[0], 1'b1, i[1] ^ i[2], 2'b10, i[2], i[1:0]}, i[1]);
    end
    gpio_oe <= 3'h0;
    xfer(8'h40, 1'b0);
    xfer(8'he4, 1'b1);
    print_verdict();
  end
endmodule
